// *** common/prc_pkg.sv ***
package prc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CTRL_PERIOD_MS  = 4;
    localparam int unsigned CTRL_PERIOD_CYC = CLK_HZ / 1000 * CTRL_PERIOD_MS;
    // Factor 2/period(s) in the braking-distance estimate
    localparam int unsigned DECEL_SCALE     = 2 * 1000 / CTRL_PERIOD_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Ports, widths, ranges
    localparam int          NPORT      = 2;
    localparam int          FW         = 17;
    localparam int          TW         = 17;
    localparam logic [31:0] FREQ_MAX   = 32'h000186a0;
    localparam logic [15:0] RATE_MIN   = 16'h0001;
    localparam logic [15:0] PORT_LAST  = 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    // Output mode word fields
    localparam int          MODE_CONT_BIT = 0;
    localparam int          MODE_ABS_BIT  = 1;
    localparam int          MODE_CCW_BIT  = 2;
    localparam int          MODE_METH_BIT = 3;
    localparam logic [15:0] MODE_LEGAL    = 16'h000f;

    ////////////////////////////////////////////////////////////////////////////
    // Commands and channel phases
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_RAMP = 2'h1,
        OP_TRAP = 2'h2,
        OP_STOP = 2'h3
    } prc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ACCEL = 2'b01,
        ST_CONST = 2'b11,
        ST_DECEL = 2'b10
    } prc_state_t;

    typedef struct packed {
        prc_op_t     op;
        logic [15:0] port;
        logic [15:0] mode;
        logic [15:0] acc_rate;
        logic [15:0] dec_rate;
        logic [31:0] target_freq;
        logic [31:0] start_freq;
        logic [31:0] pulses;
    } prc_cmd_t;

    // True once the remaining pulses no longer cover a ramp down to the floor
    function automatic logic decel_due(input logic [31:0] rem,
                                       input logic [FW-1:0] f,
                                       input logic [FW-1:0] fl,
                                       input logic [15:0] rate);
        logic [63:0] need;
        logic [63:0] have;
        need = 64'(rem) * 64'(rate) * 64'(DECEL_SCALE);
        have = (f > fl) ? (64'(f) * 64'(f) - 64'(fl) * 64'(fl)) : 64'h0;
        return need <= have;
    endfunction

endpackage

// *** verification/prc_drive_model.sv ***
`timescale 1ns/1ps
module prc_drive_model (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [1:0]    pulse_i,
    input  wire logic [1:0]    dir_i,
    output logic signed [31:0] pos0_o,
    output logic signed [31:0] pos1_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Both axes decode pulse plus direction, one shared method
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos0_o <= '0;
        end else if (pulse_i[0]) begin
            pos0_o <= dir_i[0] ? pos0_o - 32'sd1 : pos0_o + 32'sd1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos1_o <= '0;
        end else if (pulse_i[1]) begin
            pos1_o <= dir_i[1] ? pos1_o - 32'sd1 : pos1_o + 32'sd1;
        end
    end
endmodule

// *** verification/prc_ramp_properties.sv ***
`timescale 1ns/1ps
module prc_ramp_checker
    import prc_pkg::*;
#(
    parameter int unsigned CTRL_CYC = 20
) (
    input wire logic                   SYS_CLK_I,
    input wire logic                   SYS_RST_I,
    input wire logic                   CMD_VALID_I,
    input wire prc_pkg::prc_cmd_t      CMD_I,
    input wire logic                   IN_INTERRUPT_I,
    input wire logic                   CYCLIC_PULSE_BUSY_I,
    input wire logic [1:0]             HOME_SEARCH_BUSY_I,
    input wire logic [1:0]             ORIGIN_VALID_I,
    input wire logic                   RUN_MODE_I,
    input wire logic [1:0]             PULSE_O,
    input wire logic [1:0]             DIR_O,
    input wire logic [1:0]             BUSY_O,
    input wire logic [1:0][1:0]        PHASE_O,
    input wire logic [1:0][FW-1:0]     FREQ_O,
    input wire logic [1:0][31:0]       POS_O,
    input wire logic                   FAULT_O
);
    import prc_pkg::*;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire logic mv = CMD_VALID_I && (CMD_I.op == OP_RAMP || CMD_I.op == OP_TRAP);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_acc2;
        PHASE_O[0] == ST_ACCEL ##1 PHASE_O[0] == ST_ACCEL;
    endsequence
    sequence s_dec2;
        PHASE_O[0] == ST_DECEL ##1 PHASE_O[0] == ST_DECEL;
    endsequence
    a_bad_port: assert property (mv && CMD_I.port > PORT_LAST |=> FAULT_O)
        else $error("port code out of range not flagged");
    a_zero_rate: assert property (mv && CMD_I.acc_rate < RATE_MIN |=> FAULT_O)
        else $error("zero rate not flagged");
    a_big_target: assert property (mv && CMD_I.target_freq > FREQ_MAX |=> FAULT_O)
        else $error("target above limit not flagged");
    a_home_busy: assert property (mv && CMD_I.port <= PORT_LAST
        && HOME_SEARCH_BUSY_I[CMD_I.port[0]] |=> FAULT_O) else $error("home busy not flagged");
    a_irq_clash: assert property (mv && IN_INTERRUPT_I && CYCLIC_PULSE_BUSY_I |=> FAULT_O)
        else $error("interrupt clash not flagged");
    a_stop_halts: assert property (CMD_VALID_I && CMD_I.op == OP_STOP && CMD_I.port == 16'h0
        |=> PHASE_O[0] == ST_IDLE && FREQ_O[0] == '0) else $error("stop left port running");
    a_run_halts: assert property (!RUN_MODE_I |=> PHASE_O == '0 && FREQ_O == '0)
        else $error("output kept running outside run mode");
    a_accel_rises: assert property (s_acc2 |-> FREQ_O[0] >= $past(FREQ_O[0]))
        else $error("frequency fell while accelerating");
    a_decel_falls: assert property (s_dec2 |-> FREQ_O[0] <= $past(FREQ_O[0]))
        else $error("frequency rose while decelerating");
endmodule
bind prc_pulse_ramp_controller prc_ramp_checker #(.CTRL_CYC(CTRL_CYC)) prc_ramp_checker_i (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
    .IN_INTERRUPT_I(IN_INTERRUPT_I), .CYCLIC_PULSE_BUSY_I(CYCLIC_PULSE_BUSY_I),
    .HOME_SEARCH_BUSY_I(HOME_SEARCH_BUSY_I), .ORIGIN_VALID_I(ORIGIN_VALID_I),
    .RUN_MODE_I(RUN_MODE_I), .PULSE_O(PULSE_O), .DIR_O(DIR_O), .BUSY_O(BUSY_O),
    .PHASE_O(PHASE_O), .FREQ_O(FREQ_O), .POS_O(POS_O), .FAULT_O(FAULT_O));

// *** verification/test_pulse_ramp_controller.sv ***
`timescale 1ns/1ps
module test_pulse_ramp_controller;
    import prc_pkg::*;
    // Short tick keeps ramps within a few hundred cycles
    localparam int unsigned CYC = 20;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               vld = 1'b0;
    prc_cmd_t           cmd = '0;
    logic               irq = 1'b0;
    logic               cyc_busy = 1'b0;
    logic [1:0]         home = 2'h0;
    logic [1:0]         home_search_cmd = 2'h0;
    logic               run = 1'b1;
    logic [1:0]         pulse, dir, busy;
    logic [1:0][1:0]    phase;
    logic [1:0][FW-1:0] freq;
    logic [1:0][31:0]   pos;
    logic               fault;
    logic signed [31:0] drv0, drv1;
    int                 mismatches = 0;
    int                 compares = 0;
    prc_pulse_ramp_controller #(.CTRL_CYC(CYC)) prc_pulse_ramp_controller_i (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(vld), .CMD_I(cmd),
        .IN_INTERRUPT_I(irq), .CYCLIC_PULSE_BUSY_I(cyc_busy), .HOME_SEARCH_BUSY_I(home),
        .ORIGIN_VALID_I(home_search_cmd), .RUN_MODE_I(run), .PULSE_O(pulse), .DIR_O(dir), .BUSY_O(busy),
        .PHASE_O(phase), .FREQ_O(freq), .POS_O(pos), .FAULT_O(fault));
    prc_drive_model prc_drive_model_i (.clk_i(clk), .rst_i(rst), .pulse_i(pulse),
        .dir_i(dir), .pos0_o(drv0), .pos1_o(drv1));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic expire(input int k, input int lim);
        if (k >= lim) begin
            mismatches++;
            $display("mismatch at %0t: wait ran out %h %h", $time, k, lim);
            print_verdict();
        end
    endtask
    // Returns at the falling edge after BUSY_O has had time to follow
    task automatic send(input prc_op_t op, input logic [15:0] pt, input logic [15:0] md,
                        input logic [15:0] ac, input logic [15:0] dc, input logic [31:0] tg,
                        input logic [31:0] st, input logic [31:0] n);
        cmd = '{op, pt, md, ac, dc, tg, st, n};
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic next_freq(input logic [FW-1:0] ref_f, output logic [FW-1:0] f);
        int k;
        for (k = 0; k < 4*CYC && freq[0] === ref_f; k++) @(negedge clk);
        expire(k, 4*CYC);
        f = freq[0];
    endtask
    task automatic wait_idle(input int p);
        int k;
        for (k = 0; k < 60000 && busy[p] !== 1'b0; k++) @(negedge clk);
        expire(k, 60000);
    endtask
    task automatic wait_pos1(input logic [31:0] lim);
        int k;
        for (k = 0; k < 20000 && pos[1] < lim; k++) @(negedge clk);
        expire(k, 20000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ramp_cont();
        logic [FW-1:0] f;
        send(OP_RAMP, 16'h0, 16'h1, 16'h64, 16'h0, 32'h15e, 32'h0, 32'h0);
        check(phase[0], ST_ACCEL);
        next_freq(17'h0, f);
        check(f, 17'h64);
        repeat (4*CYC) @(negedge clk);
        check({phase[0], freq[0]}, {ST_CONST, 17'h15e});
        send(OP_RAMP, 16'h0, 16'h0, 16'h64, 16'h0, 32'h15e, 32'h0, 32'h10);
        check({fault, freq[0]}, {1'b1, 17'h15e});
        send(OP_RAMP, 16'h0, 16'h1, 16'h32, 16'h0, 32'h0, 32'h0, 32'h0);
        next_freq(17'h15e, f);
        check(f, 17'h0fa);
        f = freq[0];
        send(OP_RAMP, 16'h0, 16'h1, 16'h64, 16'h0, 32'h15e, 32'h0, 32'h0);
        next_freq(f, f);
        check(f, 17'h096);
        wait_idle(0);
        check({fault, phase[0], freq[0]}, '0);
        $display("test ramp_cont done");
    endtask
    task automatic t_refuse();
        prc_op_t     op;
        logic [15:0] pt, md, ac;
        logic [31:0] tg;
        for (int i = 0; i < 8; i++) begin
            op = OP_RAMP;
            {pt, md, ac, tg} = {16'h0, 16'h1, 16'h0a, 32'h64};
            case (i)
                0: pt = 16'h2;
                1: ac = 16'h0;
                2: tg = 32'h186a1;
                3: md = 16'h11;
                4: home = 2'h1;
                5: {irq, cyc_busy} = 2'h3;
                6: md = 16'h2;
                default: begin
                    op = OP_TRAP;
                    {md, ac} = 32'h0;
                end
            endcase
            send(op, pt, md, ac, 16'h0a, tg, 32'h0, 32'h5);
            check({fault, phase[0]}, {1'b1, ST_IDLE});
            {home, irq, cyc_busy} = '0;
        end
        $display("test refuse done");
    endtask
    task automatic t_trap();
        send(OP_TRAP, 16'h1, 16'h0, 16'h61a8, 16'h61a8, 32'h186a0, 32'hc350, 32'h14);
        check(fault, 1'b0);
        wait_idle(1);
        check({pos[1], drv1, dir[1]}, {32'h14, 32'h14, 1'b0});
        home_search_cmd = 2'h3;
        send(OP_TRAP, 16'h1, 16'h2, 16'h61a8, 16'h61a8, 32'h186a0, 32'hc350, 32'h3c);
        wait_pos1(32'h1e);
        send(OP_TRAP, 16'h1, 16'h2, 16'h3a98, 16'h2710, 32'h186a0, 32'hc350, 32'ha);
        check(fault, 1'b0);
        wait_idle(1);
        check({pos[1], drv1, dir[1]}, {32'ha, 32'ha, 1'b1});
        $display("test trap done");
    endtask
    task automatic t_stop();
        logic [31:0] p;
        send(OP_TRAP, 16'h0, 16'h0, 16'h61a8, 16'h61a8, 32'h186a0, 32'hc350, 32'h3e8);
        repeat (3000) @(negedge clk);
        send(OP_STOP, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0, 32'h0, 32'h0);
        check({phase[0], freq[0]}, '0);
        wait_idle(0);
        p = pos[0];
        repeat (300) @(negedge clk);
        check({pos[0], drv0, 1'(p < 32'h3e8)}, {p, p, 1'b1});
        send(OP_TRAP, 16'h0, 16'h0, 16'h61a8, 16'h61a8, 32'h186a0, 32'hc350, 32'h3e8);
        repeat (3000) @(negedge clk);
        send(OP_RAMP, 16'h0, 16'h0, 16'h61a8, 16'h0, 32'h0, 32'h0, 32'h0);
        // Phase only follows at the next control tick
        repeat (CYC) @(negedge clk);
        check({fault, phase[0]}, {1'b0, ST_DECEL});
        wait_idle(0);
        check({pos[0], 1'(pos[0] - p < 32'h3e8)}, {drv0, 1'b1});
        send(OP_RAMP, 16'h0, 16'h1, 16'h1f4, 16'h0, 32'h3e8, 32'h0, 32'h0);
        repeat (2*CYC) @(negedge clk);
        run = 1'b0;
        @(negedge clk);
        check({phase[0], freq[0]}, '0);
        run = 1'b1;
        wait_idle(0);
        $display("test stop done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({busy, phase, freq, fault}, '0);
        t_ramp_cont();
        t_refuse();
        t_trap();
        t_stop();
        print_verdict();
    end
endmodule

// *** verilog/prc_pulse_nco.sv ***
`timescale 1ns/1ps
module prc_pulse_nco (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   en_i,
    input  wire logic [prc_pkg::FW-1:0] freq_i,
    output logic                        pulse_o
);
    import prc_pkg::*;

    localparam logic [25:0] WRAP = 26'(CLK_HZ);

    logic [25:0] acc_ff;
    logic [25:0] sum;

    assign sum = acc_ff + 26'(freq_i);

    // Phase accumulator: one pulse each time CLK_HZ worth of phase wraps
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            acc_ff  <= 26'h0;
            pulse_o <= 1'b0;
        end else if (sum >= WRAP) begin
            acc_ff  <= sum - WRAP;
            pulse_o <= 1'b1;
        end else begin
            acc_ff  <= sum;
            pulse_o <= 1'b0;
        end
    end

endmodule

// *** verilog/prc_pulse_ramp_controller.sv ***
`timescale 1ns/1ps
// Operation
// - Reissued positioning command during a ramp applies its new rates from then on.
// - New absolute target mid-move decelerates, reverses and travels to the new position.
// - Immediate stop halts pulses at once and discards the remaining count.
// - Independent ramp command with zero target ramps down and stops smoothly.
// - Too few pulses for full profile gives a triangular profile, no error.
// - Ramp rate is 16 bits, 1 to 65535 Hz per 4 ms period.
// - Target frequency is 32 bits, low word first, range zero to 186a0 hex.
// - Out-of-range port, mode or settings raise the fault and refuse.
// - Command to a port running a home search raises the fault and refuses.
// - Switching independent/continuous while emitting pulses raises the fault.
// - Command from interrupt while cyclic pulse command runs raises the fault.
// - Absolute positioning without an established origin raises the fault.
// - Frequency rises by the rate each control period until target, then holds.
// - Independent mode stops after the set count; continuous runs until stopped.
// - Positioning and ramp commands are accepted in any phase of either move.
// - After a zero-target command, later moves before stopping change nothing.
// - Positioning command with zero acceleration rate raises the fault, not executed.
// - Start within the hold after a stop restarts next period; not after immediate stop.
// - Leaving run mode halts pulse generation immediately.
// - Continuous zero-target command decelerates with the rate already in effect.
module prc_pulse_ramp_controller #(
    parameter int unsigned CTRL_CYC = prc_pkg::CTRL_PERIOD_CYC
) (
    input  wire logic                        SYS_CLK_I,
    input  wire logic                        SYS_RST_I,
    input  wire logic                        CMD_VALID_I,
    input  wire prc_pkg::prc_cmd_t           CMD_I,
    input  wire logic                        IN_INTERRUPT_I,
    input  wire logic                        CYCLIC_PULSE_BUSY_I,
    input  wire logic [1:0]                  HOME_SEARCH_BUSY_I,
    input  wire logic [1:0]                  ORIGIN_VALID_I,
    input  wire logic                        RUN_MODE_I,
    output logic      [1:0]                  PULSE_O,
    output logic      [1:0]                  DIR_O,
    output logic      [1:0]                  BUSY_O,
    output logic      [1:0][1:0]             PHASE_O,
    output logic      [1:0][prc_pkg::FW-1:0] FREQ_O,
    output logic      [1:0][31:0]            POS_O,
    output logic                             FAULT_O
);
    import prc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Control period tick

    localparam logic [TW-1:0] TICK_LAST = TW'(CTRL_CYC - 1);

    logic [TW-1:0] tick_cnt_ff;
    logic          tick;

    assign tick = (tick_cnt_ff == TICK_LAST);

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I || tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command checks, shared by both ports

    logic [1:0] run_w;
    logic [1:0] cont_w;
    logic       cmd_port;
    logic       port_ok;
    logic       is_ramp;
    logic       is_trap;
    logic       is_stop;
    logic       err_rng;
    logic       err_home;
    logic       err_mode;
    logic       err_int;
    logic       err_org;
    logic       err;
    logic       mov_ok;

    assign cmd_port = CMD_I.port[0];
    assign port_ok  = (CMD_I.port <= PORT_LAST);
    assign is_ramp  = CMD_VALID_I && (CMD_I.op == OP_RAMP);
    assign is_trap  = CMD_VALID_I && (CMD_I.op == OP_TRAP);
    assign is_stop  = CMD_VALID_I && (CMD_I.op == OP_STOP);

    // Zero acceleration rate is refused here, also for the fixed-distance feed
    assign err_rng  = !port_ok
                   || ((CMD_I.mode & ~MODE_LEGAL) != 16'h0000)
                   || (CMD_I.target_freq > FREQ_MAX)
                   || (CMD_I.acc_rate < RATE_MIN)
                   || (is_trap && (CMD_I.start_freq > FREQ_MAX))
                   || (is_trap && (CMD_I.dec_rate < RATE_MIN));
    assign err_home = HOME_SEARCH_BUSY_I[cmd_port];
    assign err_mode = is_ramp && run_w[cmd_port]
                   && (cont_w[cmd_port] != CMD_I.mode[MODE_CONT_BIT]);
    assign err_int  = IN_INTERRUPT_I && CYCLIC_PULSE_BUSY_I;
    assign err_org  = CMD_I.mode[MODE_ABS_BIT]
                   && (is_trap || !CMD_I.mode[MODE_CONT_BIT])
                   && !ORIGIN_VALID_I[cmd_port];
    assign err      = (is_ramp || is_trap)
                    ? (err_rng || err_home || err_mode || err_int || err_org)
                    : (is_stop && !port_ok);
    assign mov_ok   = (is_ramp || is_trap) && !err;

    // Fault shows the outcome of the latest command
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            FAULT_O <= 1'b0;
        end else if (CMD_VALID_I && (CMD_I.op != OP_NONE)) begin
            FAULT_O <= err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse channels

    for (genvar g = 0; g < NPORT; g++) begin : g_ch
        prc_state_t        state_ff;
        logic [FW-1:0]     freq_ff;
        logic [FW-1:0]     tgt_ff;
        logic [FW-1:0]     floor_ff;
        logic [FW-1:0]     floor_lo;
        logic [FW-1:0]     eff_tgt;
        logic [FW-1:0]     nxt_freq;
        logic [15:0]       acc_ff;
        logic [15:0]       dec_ff;
        logic signed [31:0] pos_ff;
        logic signed [31:0] goal_ff;
        logic signed [31:0] rem;
        logic signed [31:0] rel_goal;
        logic signed [31:0] nxt_goal;
        logic              cont_ff;
        logic              dir_ff;
        logic              zstop_ff;
        logic              hold_ff;
        logic              hard_ff;
        logic              pend_ff;
        logic              busy_ff;
        prc_cmd_t          pcmd_ff;
        prc_cmd_t          csel;
        logic              mine;
        logic              run;
        logic              load;
        logic              take;
        logic              to_pend;
        logic              stop_imm;
        logic              pulse;
        logic              wrong;
        logic              due;
        logic              last;
        logic              fin;

        assign run      = (state_ff != ST_IDLE);
        assign mine     = mov_ok && (cmd_port == 1'(g));
        assign stop_imm = (is_stop && port_ok && (cmd_port == 1'(g)))
                       || !RUN_MODE_I;
        // Restart after a normal stop waits for the next period; after an
        // immediate stop the request is dropped
        assign to_pend  = mine && !run && hold_ff && !hard_ff;
        assign load     = (mine && (run || !hold_ff)) || (pend_ff && tick);
        assign csel     = (pend_ff && tick) ? pcmd_ff : CMD_I;
        // Moves queued behind a zero-target stop are swallowed
        assign take     = load && !(run && zstop_ff);

        assign rel_goal = csel.mode[MODE_CCW_BIT] ? pos_ff - $signed(csel.pulses)
                                                  : pos_ff + $signed(csel.pulses);
        assign nxt_goal = csel.mode[MODE_ABS_BIT] ? $signed(csel.pulses) : rel_goal;

        // Distance left along the present direction; negative means overshoot
        assign rem      = dir_ff ? pos_ff - goal_ff : goal_ff - pos_ff;
        assign wrong    = !cont_ff && (rem < 0);
        // Without a starting speed the rate itself is the last step before zero
        assign floor_lo = (floor_ff != '0) ? floor_ff : FW'(dec_ff);
        assign due      = decel_due(32'(rem), freq_ff, floor_lo, dec_ff);
        assign eff_tgt  = zstop_ff ? '0
                        : (!cont_ff && (wrong || due)) ? floor_lo
                        : tgt_ff;
        assign last     = pulse && !cont_ff && (rem == 32'sd1);
        assign fin      = run && !stop_imm && !load
                       && (last
                           || (tick && !cont_ff && (rem == 32'sd0))
                           || (tick && zstop_ff && (nxt_freq == '0)));

        prc_ramp_step u_step (
            .cur_i     (freq_ff),
            .tgt_i     (eff_tgt),
            .up_rate_i (acc_ff),
            .dn_rate_i (dec_ff),
            .nxt_o     (nxt_freq)
        );

        prc_pulse_nco u_nco (
            .clk_i   (SYS_CLK_I),
            .rst_i   (SYS_RST_I),
            .en_i    (run && !stop_imm),
            .freq_i  (freq_ff),
            .pulse_o (pulse)
        );

        // Motion profile
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                state_ff <= ST_IDLE;
                freq_ff  <= '0;
                tgt_ff   <= '0;
                floor_ff <= '0;
                acc_ff   <= 16'h0001;
                dec_ff   <= 16'h0001;
                goal_ff  <= 32'sd0;
                cont_ff  <= 1'b0;
                dir_ff   <= 1'b0;
                zstop_ff <= 1'b0;
            end else if (stop_imm) begin
                state_ff <= ST_IDLE;
                freq_ff  <= '0;
                zstop_ff <= 1'b0;
                goal_ff  <= pos_ff;
            end else if (take) begin
                if (csel.op == OP_TRAP) begin
                    acc_ff   <= csel.acc_rate;
                    dec_ff   <= csel.dec_rate;
                    tgt_ff   <= csel.target_freq[FW-1:0];
                    floor_ff <= csel.start_freq[FW-1:0];
                    cont_ff  <= 1'b0;
                    goal_ff  <= nxt_goal;
                    zstop_ff <= 1'b0;
                    if (!run) begin
                        freq_ff <= csel.start_freq[FW-1:0];
                    end
                end else begin
                    // Zero target in continuous mode keeps the rate in effect
                    if ((csel.target_freq != 32'h0) || !csel.mode[MODE_CONT_BIT]) begin
                        acc_ff <= csel.acc_rate;
                        dec_ff <= csel.acc_rate;
                    end
                    tgt_ff   <= csel.target_freq[FW-1:0];
                    cont_ff  <= csel.mode[MODE_CONT_BIT];
                    zstop_ff <= (csel.target_freq == 32'h0);
                    if (!run) begin
                        floor_ff <= '0;
                        freq_ff  <= '0;
                        goal_ff  <= nxt_goal;
                    end
                end
                if (!run) begin
                    state_ff <= ST_ACCEL;
                    dir_ff   <= csel.mode[MODE_CONT_BIT] && (csel.op == OP_RAMP)
                              ? csel.mode[MODE_CCW_BIT] : (nxt_goal < pos_ff);
                end
            end else if (fin) begin
                state_ff <= ST_IDLE;
                freq_ff  <= '0;
                zstop_ff <= 1'b0;
            end else if (run && tick) begin
                freq_ff <= nxt_freq;
                if (wrong && (freq_ff <= floor_lo)) begin
                    dir_ff <= !dir_ff;
                end
                if (nxt_freq < eff_tgt) begin
                    state_ff <= ST_ACCEL;
                end else if (nxt_freq > eff_tgt || eff_tgt < tgt_ff) begin
                    state_ff <= ST_DECEL;
                end else begin
                    state_ff <= ST_CONST;
                end
            end
        end

        // Present position follows every emitted pulse
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                pos_ff <= 32'sd0;
            end else if (pulse) begin
                pos_ff <= dir_ff ? pos_ff - 32'sd1 : pos_ff + 32'sd1;
            end
        end

        // In-progress hold after a stop and the queued restart
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                hold_ff <= 1'b0;
                hard_ff <= 1'b0;
                pend_ff <= 1'b0;
                pcmd_ff <= '0;
            end else if (stop_imm) begin
                hold_ff <= run || hold_ff;
                hard_ff <= 1'b1;
                pend_ff <= 1'b0;
            end else if (fin) begin
                hold_ff <= 1'b1;
                hard_ff <= 1'b0;
            end else if (to_pend) begin
                pend_ff <= 1'b1;
                pcmd_ff <= CMD_I;
            end else if (tick) begin
                hold_ff <= 1'b0;
                pend_ff <= 1'b0;
            end
        end

        // Registered copy for the busy output
        always_ff @(posedge SYS_CLK_I) begin
            if (SYS_RST_I) begin
                busy_ff <= 1'b0;
            end else begin
                busy_ff <= run || hold_ff;
            end
        end

        assign run_w[g]   = run;
        assign cont_w[g]  = cont_ff;
        assign PULSE_O[g] = pulse;
        assign DIR_O[g]   = dir_ff;
        assign BUSY_O[g]  = busy_ff;
        assign PHASE_O[g] = state_ff;
        assign FREQ_O[g]  = freq_ff;
        assign POS_O[g]   = pos_ff;
    end

endmodule

// *** verilog/prc_ramp_step.sv ***
`timescale 1ns/1ps
module prc_ramp_step (
    input  wire logic [prc_pkg::FW-1:0] cur_i,
    input  wire logic [prc_pkg::FW-1:0] tgt_i,
    input  wire logic [15:0]            up_rate_i,
    input  wire logic [15:0]            dn_rate_i,
    output logic      [prc_pkg::FW-1:0] nxt_o
);
    import prc_pkg::*;

    logic [FW-1:0] diff;

    always_comb begin
        diff  = '0;
        nxt_o = cur_i;
        if (cur_i < tgt_i) begin
            diff  = tgt_i - cur_i;
            // Sum cannot overflow: it stays below tgt_i
            nxt_o = (diff > FW'(up_rate_i)) ? cur_i + FW'(up_rate_i) : tgt_i;
        end else begin
            diff  = cur_i - tgt_i;
            nxt_o = (diff > FW'(dn_rate_i)) ? cur_i - FW'(dn_rate_i) : tgt_i;
        end
    end

endmodule
